//--- rtl/msc_channel.sv
// One multipurpose serial channel: serial port, bit-bang and serial engine.
// Operation
// - Every channel offers bit-bang on eight two-way data lines.
// - Only the first two channels hold the independent synchronous engine.
// - Engine drives clock, data and select, samples data, has four GP lines.
// - Other channels stay freely configurable while engines run.
// - The engine runs at no more than thirty megabits per second.
// - Each channel has a two kilobyte transmit buffer fed by the host.
// - Each channel has a two kilobyte receive buffer read on host request.
// - Asynchronous serial is the default; bit-bang only when set up.
// - The generator gives a sixteen or ten times baud sampling clock.
// - The divisor has a fourteen bit prescaler and four fraction bits.
// - Baud rates run from about 458 baud to twelve megabaud.
// - Power-on reset and the external reset pin both reset the logic.
module msc_channel
  import msc_pkg::*;
#(
  parameter bit ENGINE_CAP = 1'b1
) (
  // Clock and resets.
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ext_rst_n,
  // Register port.
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DW-1:0] o_rdata,
  // Channel data lines.
  input wire logic [LINES-1:0] i_bitbang_lines,
  output logic [LINES-1:0] o_bitbang_lines,
  output logic [LINES-1:0] o_bitbang_lines_oe
);
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  msc_baud_if bif ();

  logic rst_s1_q, rst_s2_q, rst_s3_q, ext_rst_n_q;
  logic rst;
  logic [LINES-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  msc_mode_t mode_q;
  logic osr10_q;
  logic [DIV_W-1:0] div_q;
  logic [FRAC_W-1:0] frac_q;
  logic [LINES-1:0] dir_q;
  logic [7:0] eng_div_q;
  logic eng_cs_q;
  logic [3:0] gpo_q, gpd_q;
  logic [7:0] tx_mem [BUF_DEPTH];
  logic [7:0] rx_mem [BUF_DEPTH];
  logic [BUF_AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [BUF_CW-1:0] tx_cnt_q, rx_cnt_q;
  logic tx_push, tx_pop, rx_push, rx_pop, tx_empty, rx_full;
  logic [7:0] rx_din;
  logic ovr_q, ovr_set, ovr_clr;
  logic [DW-1:0] rdata_q;
  logic [4:0] osr;
  logic [4:0] samp_cnt_q;
  logic bit_tick;
  msc_xfer_t xs_q;
  logic [8:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic txd_q;
  logic [LINES-1:0] bb_out_q;
  logic [7:0] eng_sh_q, eng_in_q, half_cnt_q, half_per;
  logic [2:0] eng_bit_q;
  logic sclk_q;
  logic xfer_push;
  logic [7:0] xfer_data;
  msc_rx_t rs_q;
  logic [4:0] rs_cnt_q;
  logic [3:0] rs_bits_q;
  logic [7:0] rs_sh_q;
  logic uart_push;
  logic [LINES-1:0] out_q, oe_q;

  // External reset pin is filtered before it joins the power-on reset.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
      rst_s3_q <= 1'b1;
      ext_rst_n_q <= 1'b1;
    end else begin
      rst_s1_q <= i_ext_rst_n;
      rst_s2_q <= rst_s1_q;
      rst_s3_q <= rst_s2_q;
      if (rst_s2_q == rst_s3_q) begin
        ext_rst_n_q <= rst_s3_q;
      end
    end
  end

  assign rst = i_srst || !ext_rst_n_q;

  // Line inputs pass three stages and settle when the last two agree.
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q <= '0;
    end else begin
      pin_s1_q <= i_bitbang_lines;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  // Configuration registers.
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      mode_q <= MODE_UART;
      osr10_q <= 1'b0;
      div_q <= '0;
      frac_q <= '0;
      dir_q <= '0;
      eng_div_q <= ENG_MIN_HALF;
      eng_cs_q <= 1'b1;
      gpo_q <= '0;
      gpd_q <= '0;
    end else if (i_wr) begin
      if (hit(i_addr, OFF_MODE)) begin
        if (msc_mode_t'(i_wdata[1:0]) == MODE_ENG && !ENGINE_CAP) begin
          mode_q <= MODE_UART;
        end else begin
          mode_q <= msc_mode_t'(i_wdata[1:0]);
        end
        osr10_q <= i_wdata[MODE_OSR10_BIT];
      end
      if (hit(i_addr, OFF_BAUD)) begin
        div_q <= i_wdata[DIV_W-1:0];
        frac_q <= i_wdata[DIV_W +: FRAC_W];
      end
      if (hit(i_addr, OFF_DIR)) begin
        dir_q <= i_wdata[LINES-1:0];
      end
      if (hit(i_addr, OFF_ENG)) begin
        eng_div_q <= i_wdata[7:0];
        eng_cs_q <= i_wdata[ENG_CS_BIT];
        gpo_q <= i_wdata[ENG_GPO_LSB +: 4];
        gpd_q <= i_wdata[ENG_GPD_LSB +: 4];
      end
    end
  end

  assign bif.div = div_q;
  assign bif.frac = frac_q;
  assign bif.en = 1'b1;

  msc_baud_gen u_baud (
    .i_core_clk(i_core_clk),
    .i_srst(rst),
    .bif(bif)
  );

  // Transmit and receive buffers.
  assign tx_empty = (tx_cnt_q == '0);
  assign rx_full = (rx_cnt_q == BUF_FULL);
  assign tx_push = i_wr && hit(i_addr, OFF_TXDATA) && (tx_cnt_q != BUF_FULL);
  assign rx_pop = i_rd && hit(i_addr, OFF_RXDATA) && (rx_cnt_q != '0);
  assign rx_push = (xfer_push || uart_push) && !rx_full;
  assign rx_din = uart_push ? rs_sh_q : xfer_data;

  always_ff @(posedge i_core_clk) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= i_wdata[7:0];
    end
    if (rx_push) begin
      rx_mem[rx_wp_q] <= rx_din;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0;
    end else begin
      if (tx_push) begin
        tx_wp_q <= tx_wp_q + 1'b1;
      end
      if (tx_pop) begin
        tx_rp_q <= tx_rp_q + 1'b1;
      end
      tx_cnt_q <= tx_cnt_q + BUF_CW'(tx_push) - BUF_CW'(tx_pop);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (rx_push) begin
        rx_wp_q <= rx_wp_q + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 1'b1;
      end
      rx_cnt_q <= rx_cnt_q + BUF_CW'(rx_push) - BUF_CW'(rx_pop);
    end
  end

  // Overrun flag; a new overrun wins over a clear in the same cycle.
  assign ovr_set = uart_push && rx_full;
  assign ovr_clr = i_wr && hit(i_addr, OFF_STATUS) && i_wdata[STAT_OVR_BIT];
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      ovr_q <= 1'b0;
    end else begin
      ovr_q <= (ovr_q && !ovr_clr) || ovr_set;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge i_core_clk) begin
    if (rst || !i_rd) begin
      rdata_q <= '0;
    end else begin
      case (i_addr)
        OFF_MODE: rdata_q <= DW'({osr10_q, mode_q});
        OFF_BAUD: rdata_q <= DW'({frac_q, div_q});
        OFF_DIR: rdata_q <= DW'(dir_q);
        OFF_RXDATA: rdata_q <= rx_pop ? DW'(rx_mem[rx_rp_q]) : '0;
        OFF_STATUS: begin
          rdata_q <= DW'({ovr_q, rx_cnt_q, tx_cnt_q});
        end
        OFF_ENG: rdata_q <= DW'({gpd_q, gpo_q, 3'h0, eng_cs_q, eng_div_q});
        OFF_PINS: rdata_q <= DW'(pin_q);
        default: rdata_q <= '0;
      endcase
    end
  end
  assign o_rdata = rdata_q;

  // Sampling ticks are counted into bit periods.
  assign osr = osr10_q ? OSR10 : OSR16;
  assign bit_tick = bif.tick && (samp_cnt_q == osr - 5'h01);
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      samp_cnt_q <= '0;
    end else if (bif.tick) begin
      samp_cnt_q <= bit_tick ? '0 : samp_cnt_q + 5'h01;
    end
  end

  // Transfer machine that drains the transmit buffer in every mode.
  assign half_per = (eng_div_q < ENG_MIN_HALF) ? ENG_MIN_HALF : eng_div_q;
  always_comb begin
    tx_pop = 1'b0;
    xfer_push = 1'b0;
    xfer_data = pin_q;
    case (xs_q)
      XS_IDLE: begin
        if (!tx_empty) begin
          case (mode_q)
            MODE_UART: tx_pop = bit_tick;
            MODE_ABB: tx_pop = bit_tick;
            MODE_SBB: begin
              tx_pop = bit_tick && !rx_full;
              xfer_push = tx_pop;
            end
            MODE_ENG: tx_pop = !rx_full;
            default: tx_pop = 1'b0;
          endcase
        end
      end
      XS_ENG: begin
        xfer_data = {eng_in_q[6:0], pin_q[L_DIN]};
        xfer_push = (half_cnt_q == half_per - 8'h01) && sclk_q
                    && (eng_bit_q == ENG_LAST_BIT);
      end
      default: begin
        tx_pop = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      xs_q <= XS_IDLE;
      tx_sh_q <= '1;
      tx_left_q <= '0;
      txd_q <= 1'b1;
      bb_out_q <= '0;
      eng_sh_q <= '0;
      eng_in_q <= '0;
      eng_bit_q <= '0;
      half_cnt_q <= '0;
      sclk_q <= 1'b0;
    end else begin
      case (xs_q)
        XS_IDLE: begin
          half_cnt_q <= '0;
          eng_bit_q <= '0;
          sclk_q <= 1'b0;
          if (tx_pop && mode_q == MODE_UART) begin
            txd_q <= 1'b0;
            tx_sh_q <= {1'b1, tx_mem[tx_rp_q]};
            tx_left_q <= UART_FRAME_BITS;
            xs_q <= XS_UART;
          end else if (tx_pop && mode_q == MODE_ENG) begin
            eng_sh_q <= tx_mem[tx_rp_q];
            xs_q <= XS_ENG;
          end else if (tx_pop) begin
            bb_out_q <= tx_mem[tx_rp_q];
          end
        end
        XS_UART: begin
          if (mode_q != MODE_UART) begin
            txd_q <= 1'b1;
            xs_q <= XS_IDLE;
          end else if (bit_tick && tx_left_q != '0) begin
            txd_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[8:1]};
            tx_left_q <= tx_left_q - 4'h1;
          end else if (bit_tick) begin
            xs_q <= XS_IDLE;
          end
        end
        XS_ENG: begin
          if (mode_q != MODE_ENG) begin
            xs_q <= XS_IDLE;
          end else if (half_cnt_q != half_per - 8'h01) begin
            half_cnt_q <= half_cnt_q + 8'h01;
          end else begin
            half_cnt_q <= '0;
            sclk_q <= !sclk_q;
            if (sclk_q) begin
              eng_in_q <= {eng_in_q[6:0], pin_q[L_DIN]};
              eng_sh_q <= {eng_sh_q[6:0], 1'b0};
              eng_bit_q <= eng_bit_q + 3'h1;
              xs_q <= (eng_bit_q == ENG_LAST_BIT) ? XS_IDLE : XS_ENG;
            end
          end
        end
        default: begin
          xs_q <= XS_IDLE;
        end
      endcase
    end
  end

  // Serial receiver, active in serial port mode only.
  always_ff @(posedge i_core_clk) begin
    if (rst || mode_q != MODE_UART) begin
      rs_q <= RS_IDLE;
      rs_cnt_q <= '0;
      rs_bits_q <= '0;
      rs_sh_q <= '0;
      uart_push <= 1'b0;
    end else begin
      uart_push <= 1'b0;
      if (bif.tick) begin
        rs_cnt_q <= rs_cnt_q + 5'h01;
        case (rs_q)
          RS_IDLE: begin
            rs_cnt_q <= '0;
            if (!pin_q[L_RXD]) begin
              rs_q <= RS_START;
            end
          end
          RS_START: begin
            if (rs_cnt_q == (osr >> 1) - 5'h01) begin
              rs_cnt_q <= '0;
              rs_bits_q <= '0;
              rs_q <= pin_q[L_RXD] ? RS_IDLE : RS_DATA;
            end
          end
          RS_DATA: begin
            if (rs_cnt_q == osr - 5'h01) begin
              rs_cnt_q <= '0;
              rs_sh_q <= {pin_q[L_RXD], rs_sh_q[7:1]};
              rs_bits_q <= rs_bits_q + 4'h1;
              if (rs_bits_q == UART_LAST_BIT) begin
                rs_q <= RS_STOP;
              end
            end
          end
          RS_STOP: begin
            if (rs_cnt_q == osr - 5'h01) begin
              uart_push <= pin_q[L_RXD];
              rs_q <= RS_IDLE;
            end
          end
          default: begin
            rs_q <= RS_IDLE;
          end
        endcase
      end
    end
  end

  // Line drivers per mode.
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      out_q <= '0;
      oe_q <= '0;
    end else begin
      case (mode_q)
        MODE_UART: begin
          out_q <= LINES'(txd_q);
          oe_q <= UART_OE;
        end
        MODE_ENG: begin
          out_q <= {gpo_q, eng_cs_q, 1'b0, eng_sh_q[7], sclk_q};
          oe_q <= {gpd_q, 1'b1, 1'b0, 1'b1, 1'b1};
        end
        default: begin
          out_q <= bb_out_q;
          oe_q <= dir_q;
        end
      endcase
    end
  end
  assign o_bitbang_lines = out_q;
  assign o_bitbang_lines_oe = oe_q;
endmodule : msc_channel

//--- shared/msc_pkg.sv
// Shared constants and types for the serial channel controller.
package msc_pkg;
  localparam int DW = 32;
  localparam int AW = 8;
  localparam int LINES = 8;
  localparam int BUF_DEPTH = 2048;
  localparam int BUF_AW = 11;
  localparam int BUF_CW = 12;
  localparam logic [BUF_CW-1:0] BUF_FULL = 12'h800;
  localparam logic [AW-1:0] OFF_MODE = 8'h00;
  localparam logic [AW-1:0] OFF_BAUD = 8'h04;
  localparam logic [AW-1:0] OFF_DIR = 8'h08;
  localparam logic [AW-1:0] OFF_TXDATA = 8'h0C;
  localparam logic [AW-1:0] OFF_RXDATA = 8'h10;
  localparam logic [AW-1:0] OFF_STATUS = 8'h14;
  localparam logic [AW-1:0] OFF_ENG = 8'h18;
  localparam logic [AW-1:0] OFF_PINS = 8'h1C;
  localparam int MODE_OSR10_BIT = 2;
  localparam int DIV_W = 14;
  localparam int FRAC_W = 4;
  localparam int STAT_RX_LSB = 12;
  localparam int STAT_OVR_BIT = 24;
  localparam int ENG_CS_BIT = 8;
  localparam int ENG_GPO_LSB = 12;
  localparam int ENG_GPD_LSB = 16;
  localparam int L_SCLK = 0;
  localparam int L_DOUT = 1;
  localparam int L_DIN = 2;
  localparam int L_CS = 3;
  localparam int L_TXD = 0;
  localparam int L_RXD = 1;
  localparam logic [7:0] UART_OE = 8'h01;
  localparam logic [4:0] OSR16 = 5'h10;
  localparam logic [4:0] OSR10 = 5'h0A;
  localparam logic [3:0] UART_LAST_BIT = 4'h7;
  localparam logic [3:0] UART_FRAME_BITS = 4'h9;
  localparam logic [2:0] ENG_LAST_BIT = 3'h7;
  localparam int CORE_CLK_HZ = 200_000_000;
  localparam int REF_CLK_HZ = 120_000_000;
  localparam int REF_STEP_HZ = 1_000_000;
  localparam logic [8:0] REF_INC = 9'(REF_CLK_HZ / REF_STEP_HZ);
  localparam logic [8:0] REF_MOD = 9'(CORE_CLK_HZ / REF_STEP_HZ);
  localparam logic [18:0] FRAC_ONE = 19'h00010;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ENG_MIN_PERIOD_PS = 33333;
  localparam int ENG_MIN_HALF_CYC =
      (ENG_MIN_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] ENG_MIN_HALF = 8'(ENG_MIN_HALF_CYC);

  typedef enum logic [1:0] {
    MODE_UART = 2'b00,
    MODE_ABB = 2'b01,
    MODE_ENG = 2'b10,
    MODE_SBB = 2'b11
  } msc_mode_t;

  typedef enum logic [1:0] {
    XS_IDLE = 2'b00,
    XS_UART = 2'b01,
    XS_ENG = 2'b10
  } msc_xfer_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_START = 2'b01,
    RS_DATA = 2'b10,
    RS_STOP = 2'b11
  } msc_rx_t;
endpackage : msc_pkg

//--- shared/msc_baud_if.sv
// Link between the channel controller and its baud rate generator.
interface msc_baud_if;
  logic [13:0] div;
  logic [3:0] frac;
  logic en;
  logic tick;
  modport ctrl(output div, output frac, output en, input tick);
  modport gen(input div, input frac, input en, output tick);
endinterface : msc_baud_if

//--- rtl/msc_baud_gen.sv
// Fractional baud rate generator producing the sampling tick.
module msc_baud_gen
  import msc_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Divisor link.
  msc_baud_if.gen bif
);
  logic [8:0] ref_acc_q;
  logic [18:0] frac_acc_q;
  logic tick_q;
  logic ref_tick;
  logic [8:0] ref_sum;
  logic [18:0] target;
  logic [18:0] frac_sum;

  assign ref_sum = ref_acc_q + REF_INC;
  assign ref_tick = (ref_sum >= REF_MOD);
  assign target = ({1'b0, bif.div, bif.frac} < FRAC_ONE) ? FRAC_ONE
                  : {1'b0, bif.div, bif.frac};
  assign frac_sum = frac_acc_q + FRAC_ONE;
  assign bif.tick = tick_q;

  // The reference tick recreates the slower reference clock from the core clock.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !bif.en) begin
      ref_acc_q <= '0;
    end else if (ref_tick) begin
      ref_acc_q <= ref_sum - REF_MOD;
    end else begin
      ref_acc_q <= ref_sum;
    end
  end

  // Divides by the whole prescaler plus the fraction in sixteenths.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !bif.en) begin
      frac_acc_q <= '0;
      tick_q <= 1'b0;
    end else if (ref_tick && frac_sum >= target) begin
      frac_acc_q <= frac_sum - target;
      tick_q <= 1'b1;
    end else if (ref_tick) begin
      frac_acc_q <= frac_sum;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
    end
  end
endmodule : msc_baud_gen

//--- testbench/msc_channel_assertions.sv
// Port-level checks of the serial channel controller.
module msc_chk
  import msc_pkg::*;
#(
  parameter bit ENGINE_CAP = 1'b1
) (
  // Clock and resets.
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ext_rst_n,
  // Register port.
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DW-1:0] o_rdata,
  // Data lines.
  input wire logic [LINES-1:0] i_bitbang_lines,
  input wire logic [LINES-1:0] o_bitbang_lines,
  input wire logic [LINES-1:0] o_bitbang_lines_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rst;
  logic [1:0] mode_q;
  logic [7:0] dir_q;
  assign rst = i_srst || !i_ext_rst_n;
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      mode_q <= 2'h0;
    end else if (i_wr && i_addr == OFF_MODE) begin
      mode_q <= (i_wdata[1:0] == 2'h2 && !ENGINE_CAP) ? 2'h0 : i_wdata[1:0];
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      dir_q <= 8'h00;
    end else if (i_wr && i_addr == OFF_DIR) begin
      dir_q <= i_wdata[7:0];
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  rdata_idle_a: assert property (disable iff (rst) !$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside read answer cycle");
  unmapped_read_a: assert property (disable iff (rst) i_rd && i_addr > OFF_PINS |=> o_rdata == '0)
    else $error("unmapped read returned data");
  reset_quiet_a: assert property (i_srst |=> o_bitbang_lines_oe == '0 && o_bitbang_lines == '0)
    else $error("lines driven during reset");
  reset_release_a: assert property (disable iff (!i_ext_rst_n)
    $fell(i_srst) |=> o_bitbang_lines_oe == UART_OE && o_bitbang_lines[L_TXD])
    else $error("serial idle not set after reset");
  ext_reset_a: assert property (!i_ext_rst_n [*6] |=> o_bitbang_lines_oe == '0)
    else $error("external reset not applied");
  serial_oe_a: assert property (disable iff (rst)
    (mode_q == 2'h0) [*8] |-> o_bitbang_lines_oe == UART_OE)
    else $error("serial mode enables wrong");
  bitbang_oe_a: assert property (disable iff (rst)
    (mode_q[0] && $stable(dir_q)) [*4] |-> o_bitbang_lines_oe == dir_q)
    else $error("bit-bang enables differ from direction");
  engine_oe_a: assert property (disable iff (rst)
    (mode_q == 2'h2) [*8] |-> o_bitbang_lines_oe[3:0] == 4'hB)
    else $error("engine line directions wrong");
  engine_half_a: assert property (disable iff (rst)
    mode_q == 2'h2 && $rose(o_bitbang_lines[L_SCLK]) |-> o_bitbang_lines[L_SCLK] [*4])
    else $error("engine clock high too short");
  eng_clk_c: cover property (mode_q == 2'h2 && $rose(o_bitbang_lines[L_SCLK]));
  rx_read_c: cover property (i_rd && i_addr == OFF_RXDATA ##1 o_rdata != '0);
  ext_rst_c: cover property (!i_ext_rst_n [*6]);
endmodule : msc_chk

bind msc_channel msc_chk #(.ENGINE_CAP(ENGINE_CAP)) msc_chk_inst (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_ext_rst_n(i_ext_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_bitbang_lines(i_bitbang_lines), .o_bitbang_lines(o_bitbang_lines),
  .o_bitbang_lines_oe(o_bitbang_lines_oe)
);

//--- testbench/msc_peer.sv
// Far-side peripheral model that drives the lines the channel leaves free.
module msc_peer
  import msc_pkg::*;
(
  // Channel drive.
  input wire logic [LINES-1:0] i_dev_lines,
  input wire logic [LINES-1:0] i_dev_oe,
  // Levels put on spare lines.
  input wire logic [3:0] i_pattern,
  // Resolved wire levels.
  output logic [LINES-1:0] o_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LINES-1:0] drv;
  always_comb begin
    drv = {i_pattern, i_pattern};
    if (i_dev_oe[L_TXD] && !i_dev_oe[L_RXD]) begin
      drv[L_RXD] = i_dev_lines[L_TXD];
    end
    if (i_dev_oe[L_DOUT] && !i_dev_oe[L_DIN]) begin
      drv[L_DIN] = i_dev_lines[L_DOUT];
    end
    o_wire = (i_dev_oe & i_dev_lines) | (~i_dev_oe & drv);
  end
endmodule : msc_peer

//--- testbench/msc_channel_tb_top.sv
// Self-checking bench for the serial channel controller.
module msc_channel_tb_top
  import msc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_ext_rst_n = 1'b1;
  logic [AW-1:0] i_addr = '0;
  logic [DW-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] pattern = 4'hF;
  logic [DW-1:0] rdata [2];
  logic [LINES-1:0] lout [2];
  logic [LINES-1:0] loe [2];
  logic [LINES-1:0] wire_lv [2];
  logic [DW-1:0] got;
  logic [2:0] osr10 = 3'b010;
  logic [DW-1:0] baud [3] = '{32'h1, 32'h1, 32'h00020002};
  int lo [3] = '{26, 16, 66};
  int n;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #2.5 i_core_clk = ~i_core_clk;

  for (genvar g = 0; g < 2; g++) begin : g_ch
    msc_channel #(.ENGINE_CAP(1'(g == 0))) msc_channel_inst (
      .i_core_clk(i_core_clk), .i_srst(i_srst), .i_ext_rst_n(i_ext_rst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata[g]),
      .i_bitbang_lines(wire_lv[g]), .o_bitbang_lines(lout[g]), .o_bitbang_lines_oe(loe[g])
    );
    msc_peer msc_peer_inst (
      .i_dev_lines(lout[g]), .i_dev_oe(loe[g]), .i_pattern(pattern), .o_wire(wire_lv[g])
    );
  end

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    got = rdata[0];
    @(posedge i_core_clk);
  endtask : rd

  task automatic wait_rx(input int want, input int tries);
    repeat (tries) begin
      rd(OFF_STATUS);
      if (got[STAT_RX_LSB +: 12] >= 12'(want)) break;
    end
  endtask : wait_rx

  task automatic wait_hi(input logic [3:0] v);
    for (int t = 0; t < 300 && lout[0][7:4] !== v; t++) @(negedge i_core_clk);
    @(posedge i_core_clk);
  endtask : wait_hi

  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    repeat (5) @(posedge i_core_clk);
    i_srst <= 1'b0;
    @(posedge i_core_clk);
    @(negedge i_core_clk);
    check("oe", loe[0], UART_OE);
    check("idle", lout[0][L_TXD], 1'b1);
    @(posedge i_core_clk);
    rd(OFF_STATUS);
    check("status", got, '0);
    rd(8'h20);
    check("unmapped", got, '0);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      wr(OFF_MODE, 32'(osr10[k]) << MODE_OSR10_BIT);
      wr(OFF_BAUD, baud[k]);
      wr(OFF_TXDATA, 32'h01);
      n = 0;
      for (int t = 0; t < 3000 && lout[0][L_TXD]; t++) @(negedge i_core_clk);
      while (!lout[0][L_TXD] && n < 200) begin
        @(negedge i_core_clk);
        n++;
      end
      check("bit time", 32'(n >= lo[k] && n <= lo[k] + 1), 1);
      @(posedge i_core_clk);
      wr(OFF_TXDATA, 32'hC3);
      wait_rx(2, 700);
      rd(OFF_RXDATA);
      check("rx first", got[7:0], 8'h01);
      rd(OFF_RXDATA);
      check("rx second", got[7:0], 8'hC3);
    end
    $display("test serial done");
    wr(OFF_ENG, 32'h000FA004);
    wr(OFF_MODE, 32'h2);
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk);
    check("eng oe", loe[0], 8'hFB);
    check("eng gp", lout[0][7:4], 4'hA);
    check("eng sel", lout[0][L_CS], 1'b0);
    check("other oe", loe[1], UART_OE);
    @(posedge i_core_clk);
    wr(OFF_TXDATA, 32'h96);
    wait_rx(1, 100);
    rd(OFF_RXDATA);
    check("eng rx", got[7:0], 8'h96);
    $display("test engine done");
    wr(OFF_DIR, 32'hF0);
    pattern <= 4'h6;
    wr(OFF_MODE, 32'h1);
    wr(OFF_TXDATA, 32'h5A);
    wait_hi(4'h5);
    check("abb out", lout[0][7:4], 4'h5);
    repeat (4) @(posedge i_core_clk);
    rd(OFF_PINS);
    check("pins", got[7:0], 8'h56);
    wr(OFF_MODE, 32'h3);
    wr(OFF_TXDATA, 32'hC3);
    wait_hi(4'hC);
    check("sbb out", lout[0][7:4], 4'hC);
    rd(OFF_RXDATA);
    check("sbb rx", got[7:0], 8'h56);
    $display("test bit-bang done");
    wr(OFF_MODE, 32'h0);
    wr(OFF_BAUD, 32'h3FFF);
    repeat (2050) wr(OFF_TXDATA, 32'h55);
    rd(OFF_STATUS);
    check("tx full", got[11:0], 12'h800);
    i_srst <= 1'b1;
    @(posedge i_core_clk);
    i_srst <= 1'b0;
    @(posedge i_core_clk);
    rd(OFF_STATUS);
    check("after reset", got, '0);
    $display("test fill done");
    i_ext_rst_n <= 1'b0;
    repeat (8) @(posedge i_core_clk);
    @(negedge i_core_clk);
    check("ext oe", loe[0], '0);
    @(posedge i_core_clk);
    i_ext_rst_n <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    @(negedge i_core_clk);
    check("ext release", loe[0], UART_OE);
    $display("test ext reset done");
    end_of_test();
  end
endmodule : msc_channel_tb_top
